// ---- src/atws_code_format.v ----
/*
 * Result coding: maps a raw signed difference into the output code.
 * Assumes raw is the signed 12-bit difference scaled to the selected range.
 */
`timescale 1ns/1ns
`include "atws_regs.vh"

module atws_code_format (
    // mode
    input  wire        singleEnded,
    input  wire        polarityBip,
    // data
    input  wire [11:0] rawDiff,
    output reg  [11:0] codeOut,
    output wire        bipolarActive
);
    // single-ended forces unipolar
    assign bipolarActive = polarityBip & ~singleEnded;

    always @* begin
        if (bipolarActive) begin
            codeOut = rawDiff;                     // two's complement
        end else if (rawDiff[11]) begin
            codeOut = 12'h000;                     // negative clamps to zero
        end else begin
            codeOut = {rawDiff[10:0], 1'b0};       // straight binary 0..VREF
        end
    end
endmodule

// ---- src/atws_regs.vh ----
/*
 * Constants of the two-wire slave setup block: bus address, byte layouts,
 * reset values and timing figures.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
// Summary of operation
// - differential mode: polarity field picks unipolar or bipolar coding
// - unipolar mode: negative differential input gives output code zero
// - result is straight binary when unipolar, two's complement when bipolar
// - single-ended input always uses unipolar coding, polarity ignored
// - one data bit per serial clock; a transfer spans at least 18 clocks
// - data change during high clock is a start or stop, never data
// - idle bus leaves data and clock released high
// - repeated start keeps bus claimed and timing mode unchanged
// - acknowledge: receiver holds data low through ninth clock high phase
// - not-acknowledge: receiver leaves data high through ninth clock high
// - idle slave waits for start plus own 7-bit address before any data
// - address byte bit 0 gives direction: 0 write, 1 read
// - slave acknowledges its own address with data low one clock
// - power-up uses fast-mode timing; high-speed mode needed for full rate
// - master code 0000 1XXX is not-acknowledged, then high-speed mode (set here as the not-ack clock begins)
// - stop while in high-speed mode returns to fast-mode timing
// - written byte with top bit 1 is setup, top bit 0 is configuration
// - one or two bytes any order, each acknowledged, end by stop or restart
// - setup bit 2 set means bipolar, clear unipolar; unipolar after reset
// - setup reset bit 0 restores configuration defaults; 1 does nothing
// - internal clock mode: hold clock low while conversions run after address
// - scan-select field defaults to 00 at power-up
// - configuration bit 0: 1 single-ended, 0 differential
`ifndef ATWS_REGS_VH
`define ATWS_REGS_VH

// own address, arbitrary value
`define ATWS_OWN_ADDR        7'h2A
`define ATWS_HS_CODE_HI      5'h01
`define ATWS_BYTE_KIND_BIT   7
// setup byte fields
`define ATWS_SU_REF_HI       6
`define ATWS_SU_REF_LO       4
`define ATWS_SU_CLK_BIT      3
`define ATWS_SU_POL_BIT      2
`define ATWS_SU_RST_BIT      1
`define ATWS_SETUP_RESET     8'h80
// configuration byte fields
`define ATWS_CF_SCAN_HI      6
`define ATWS_CF_SCAN_LO      5
`define ATWS_CF_CHAN_HI      4
`define ATWS_CF_CHAN_LO      1
`define ATWS_CF_SGL_BIT      0
`define ATWS_CONFIG_RESET    8'h01
// conversion hold: time in ns and cycles at 50 ns per clock
`define ATWS_CONV_NS         10000
`define ATWS_CLK_NS          50
`define ATWS_CONV_CYC        ((`ATWS_CONV_NS + `ATWS_CLK_NS - 1) / `ATWS_CLK_NS)
`define ATWS_CNT_W           8
`define ATWS_MIN_XFER_CLKS   18

`endif

// ---- src/atws_slave.v ----
/*
 * Two-wire slave front end: start/stop detection, address match, write of
 * setup and configuration bytes, high-speed master code, clock stretch.
 * Assumes sclIn and sdaIn are raw pins; both pass two flip-flops here.
 */
`timescale 1ns/1ns
`include "atws_regs.vh"

module atws_slave (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // bus pins
    input  wire        sclIn,
    output wire        sclOut,
    output wire        sclOe,
    input  wire        sdaIn,
    output wire        sdaOut,
    output wire        sdaOe,
    // conversion side
    input  wire [11:0] rawDiff,
    output wire [11:0] resultCode,
    output wire        bipolarActive,
    output wire        convBusy,
    // decoded setup fields
    output wire [2:0]  referenceSelect,
    output wire        externalClock,
    output wire        polaritySelect,
    // decoded configuration fields
    output wire [1:0]  scanSelect,
    output wire [3:0]  channelSelect,
    output wire        singleEndedSelect,
    // status
    output wire        highSpeedMode,
    output wire        busBusy,
    output wire        addressed,
    output wire        readDir
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_HOLD = 3'h6;

    reg  [1:0]  sclSync_r;
    reg  [1:0]  sdaSync_r;
    reg         sclPrev_r;
    reg         sdaPrev_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [3:0]  bitCnt_r;
    reg  [7:0]  shift_r;
    reg         ackDrive_r;
    reg         busBusy_r;
    reg         hsMode_r;
    reg         readDir_r;
    reg         isMaster_r;
    reg  [7:0]  setup_r;
    reg  [7:0]  config_r;
    reg  [`ATWS_CNT_W-1:0] convCnt_r;
    reg  [11:0] result_r;
    wire [11:0] resultComb;

    wire scl = sclSync_r[1];
    wire sda = sdaSync_r[1];
    wire sclRise = scl & ~sclPrev_r;
    wire sclFall = ~scl & sclPrev_r;
    // data edges with clock high are control conditions
    wire startCond = scl & sclPrev_r & sdaPrev_r & ~sda;
    wire stopCond  = scl & sclPrev_r & ~sdaPrev_r & sda;
    wire [7:0] byteIn = {shift_r[6:0], sda};
    // integer count cut on purpose to the counter width
    localparam integer CONV_CYC_INT = `ATWS_CONV_CYC;
    wire [`ATWS_CNT_W-1:0] convCycles = CONV_CYC_INT[`ATWS_CNT_W-1:0];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclPrev_r <= sclSync_r[1];
            sdaPrev_r <= sdaSync_r[1];
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_ADDR: if (sclRise && bitCnt_r == 4'h7) begin
                state_nxt = ST_AACK;
            end
            ST_AACK: if (sclFall && bitCnt_r == 4'h9) begin
                if (isMaster_r || !ackDrive_r) begin
                    state_nxt = ST_IDLE;           // mismatch or master code
                end else if (readDir_r && !setup_r[`ATWS_SU_CLK_BIT]) begin
                    state_nxt = ST_HOLD;           // internal clock stretches
                end else if (readDir_r) begin
                    state_nxt = ST_READ;
                end else begin
                    state_nxt = ST_WDAT;
                end
            end
            ST_WDAT: if (sclRise && bitCnt_r == 4'h7) begin
                state_nxt = ST_WACK;
            end
            ST_WACK: if (sclFall && bitCnt_r == 4'h9) begin
                state_nxt = ST_WDAT;               // more bytes until stop
            end
            // leave on the last count so the stretch lasts exactly the hold length
            ST_HOLD: if (convCnt_r[`ATWS_CNT_W-1:1] == {(`ATWS_CNT_W-1){1'b0}}) begin
                state_nxt = ST_READ;
            end
            ST_READ: state_nxt = ST_READ;          // read-out of results lies elsewhere
            default: state_nxt = ST_IDLE;
        endcase
        // start always restarts address phase, stop always frees the bus
        if (startCond) begin
            state_nxt = ST_ADDR;
        end else if (stopCond) begin
            state_nxt = ST_IDLE;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            bitCnt_r   <= 4'h0;
            shift_r    <= 8'h00;
            ackDrive_r <= 1'b0;
            busBusy_r  <= 1'b0;
            hsMode_r   <= 1'b0;                    // fast mode after power-up
            readDir_r  <= 1'b0;
            isMaster_r <= 1'b0;
            setup_r    <= `ATWS_SETUP_RESET;       // unipolar, ref 000, internal
            config_r   <= `ATWS_CONFIG_RESET;      // scan 00
            convCnt_r  <= {`ATWS_CNT_W{1'b0}};
            result_r   <= 12'h000;
        end else begin
            state_r <= state_nxt;
            if (startCond) begin
                busBusy_r <= 1'b1;                 // repeated start keeps hsMode_r
                bitCnt_r  <= 4'h0;
                ackDrive_r <= 1'b0;
            end else if (stopCond) begin
                busBusy_r  <= 1'b0;
                hsMode_r   <= 1'b0;                // stop leaves high-speed
                ackDrive_r <= 1'b0;                // released when idle
            end else begin
                if (sclRise) begin
                    shift_r  <= byteIn;            // one bit per clock
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
                if (sclRise && bitCnt_r == 4'h7 && state_r == ST_ADDR) begin
                    readDir_r  <= sda;             // direction bit
                    isMaster_r <= (byteIn[7:3] == `ATWS_HS_CODE_HI);
                end
                if (sclFall && bitCnt_r == 4'h8) begin
                    if (state_r == ST_AACK) begin
                        // own address acked; master code left high
                        ackDrive_r <= !isMaster_r && shift_r[7:1] == `ATWS_OWN_ADDR;
                        if (isMaster_r) begin
                            hsMode_r <= 1'b1;      // high-speed set as the not-ack clock begins
                        end
                    end else if (state_r == ST_WACK) begin
                        ackDrive_r <= 1'b1;        // every written byte acked
                        if (shift_r[`ATWS_BYTE_KIND_BIT]) begin
                            setup_r <= shift_r;    // top bit 1 is setup
                            if (!shift_r[`ATWS_SU_RST_BIT]) begin
                                config_r <= `ATWS_CONFIG_RESET;
                            end
                        end else begin
                            config_r <= shift_r;   // top bit 0 is configuration
                        end
                    end
                end
                if (sclFall && bitCnt_r == 4'h9) begin
                    ackDrive_r <= 1'b0;            // held one clock only
                    bitCnt_r   <= 4'h0;
                    if (state_r == ST_AACK && ackDrive_r && readDir_r) begin
                        convCnt_r <= convCycles;
                    end
                end
                if (state_r == ST_HOLD && convCnt_r != {`ATWS_CNT_W{1'b0}}) begin
                    convCnt_r <= convCnt_r - {{(`ATWS_CNT_W-1){1'b0}}, 1'b1};
                    if (convCnt_r == {{(`ATWS_CNT_W-1){1'b0}}, 1'b1}) begin
                        result_r <= resultComb;
                    end
                end
            end
        end
    end

    atws_code_format u_format (
        .singleEnded   (config_r[`ATWS_CF_SGL_BIT]),
        .polarityBip   (setup_r[`ATWS_SU_POL_BIT]),
        .rawDiff       (rawDiff),
        .codeOut       (resultComb),
        .bipolarActive (bipolarActive)
    );

    // open-drain pins only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe  = ackDrive_r;
    assign sclOut = 1'b0;
    assign sclOe  = (state_r == ST_HOLD);

    assign resultCode        = result_r;
    assign convBusy          = (state_r == ST_HOLD);
    // bit 0 of setup is never decoded
    assign referenceSelect   = setup_r[`ATWS_SU_REF_HI:`ATWS_SU_REF_LO];
    assign externalClock     = setup_r[`ATWS_SU_CLK_BIT];
    assign polaritySelect    = setup_r[`ATWS_SU_POL_BIT];
    assign scanSelect        = config_r[`ATWS_CF_SCAN_HI:`ATWS_CF_SCAN_LO];
    assign channelSelect     = config_r[`ATWS_CF_CHAN_HI:`ATWS_CF_CHAN_LO];
    assign singleEndedSelect = config_r[`ATWS_CF_SGL_BIT];
    assign highSpeedMode     = hsMode_r;
    assign busBusy           = busBusy_r;
    assign addressed         = (state_r == ST_WDAT) || (state_r == ST_WACK) ||
                               (state_r == ST_READ) || (state_r == ST_HOLD);
    assign readDir           = readDir_r;
endmodule

// ---- tb/atws_checker.sv ----
/*
 * Port assertions for the two-wire slave setup block.
 * Assumes binding onto atws_slave; one clock domain.
 */
`timescale 1ns/1ns
module atws_checker (
    // clock and reset
    input logic        clk,
    input logic        rst,
    // watched ports
    input logic        sclOe,
    input logic        sdaOut,
    input logic        sdaOe,
    input logic [11:0] rawDiff,
    input logic [11:0] resultCode,
    input logic        bipolarActive,
    input logic        convBusy,
    input logic        externalClock,
    input logic        polaritySelect,
    input logic        singleEndedSelect,
    input logic        highSpeedMode,
    input logic        busBusy
);
    logic [8:0] holdCnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            holdCnt_r <= 9'h000;
        else
            holdCnt_r <= sclOe ? holdCnt_r + 9'h001 : 9'h000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_sdaOpenDrain; sdaOe |-> sdaOut == 1'b0; endproperty
    a_sdaOpenDrain: assert property (p_sdaOpenDrain) else $error("sda driven high");
    property p_stretch; sclOe |-> convBusy && !externalClock; endproperty
    a_stretch: assert property (p_stretch) else $error("stretch not busy");
    property p_bip; bipolarActive == (polaritySelect && !singleEndedSelect); endproperty
    a_bip: assert property (p_bip) else $error("coding mode wrong");
    property p_uniNeg; $fell(convBusy) && !bipolarActive && rawDiff[11] |-> resultCode == 12'h000; endproperty
    a_uniNeg: assert property (p_uniNeg) else $error("negative not zero");
    property p_bipPass; $fell(convBusy) && bipolarActive |-> resultCode == rawDiff; endproperty
    a_bipPass: assert property (p_bipPass) else $error("bipolar code wrong");
    property p_ackBusy; sdaOe |-> busBusy; endproperty
    a_ackBusy: assert property (p_ackBusy) else $error("ack outside frame");
    property p_holdLen; $fell(sclOe) |-> holdCnt_r == 9'h0C8; endproperty
    a_holdLen: assert property (p_holdLen) else $error("hold length wrong");
    property p_ackLen; $rose(sdaOe) |-> sdaOe [*6]; endproperty
    a_ackLen: assert property (p_ackLen) else $error("ack too short");
    property p_hsStop; $fell(busBusy) |-> ##[0:2] !highSpeedMode; endproperty
    a_hsStop: assert property (p_hsStop) else $error("stop kept high speed");
endmodule
bind atws_slave atws_checker chk (.clk, .rst, .sclOe, .sdaOut, .sdaOe, .rawDiff, .resultCode,
    .bipolarActive, .convBusy, .externalClock, .polaritySelect, .singleEndedSelect,
    .highSpeedMode, .busBusy);

// ---- tb/atws_master.sv ----
/*
 * Bus master model for the two-wire slave: open-drain pulls on both wires.
 * Assumes the bench resolves each wire with a pull-up and feeds it back.
 */
`timescale 1ns/1ns
module atws_master (
    // clock
    input  wire logic clk,
    // resolved wires
    input  wire logic sclW,
    input  wire logic sdaW,
    // pulls, high drives the wire low
    output logic      sclLow,
    output logic      sdaLow
);
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    // 4 clk half period gives the 400 ns link period
    task automatic half;
        repeat (4) @(negedge clk);
    endtask
    // a slave may stretch the clock, so the wait is bounded, not blind
    task automatic sclUp;
        sclLow = 1'b0;
        for (int i = 0; i < 400 && !sclW; i++)
            @(negedge clk);
    endtask
    task automatic bitx(input logic b, output logic r);
        repeat (2) @(negedge clk);
        sdaLow = !b;
        repeat (2) @(negedge clk);
        sclUp();
        half();
        r = sdaW;
        sclLow = 1'b1;
    endtask
    task automatic start;
        half();
        sdaLow = 1'b0;
        half();
        sclUp();
        half();
        sdaLow = 1'b1;
        half();
        sclLow = 1'b1;
    endtask
    task automatic stop;
        half();
        sdaLow = 1'b1;
        half();
        sclUp();
        half();
        sdaLow = 1'b0;
        half();
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
endmodule

// ---- tb/testbench.sv ----
/*
 * Testbench for the two-wire slave setup block: writes, reads, master code.
 * Assumes atws_master drives the link and pull-ups resolve both wires.
 */
`timescale 1ns/1ns
`include "atws_regs.vh"
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] rawDiff = 12'h000;
    logic        ack;
    logic        mSclLow, mSdaLow, sclOut, sdaOut, sclOe, sdaOe, bipolarActive, convBusy;
    logic        externalClock, polaritySelect, singleEndedSelect, highSpeedMode;
    logic        busBusy, addressed, readDir;
    logic [11:0] resultCode;
    logic [2:0]  referenceSelect;
    logic [1:0]  scanSelect;
    logic [3:0]  channelSelect;
    int          errTotal = 0;
    int          checks = 0;
    // last entry reads with external clock: no hold, result must stay as it was
    logic [7:0]  suTab [5] = '{8'hA6, 8'h82, 8'h82, 8'hA4, 8'hAC};
    logic [11:0] rawTab [5] = '{12'hF00, 12'hF00, 12'h123, 12'hF00, 12'h123};
    logic [11:0] expTab [5] = '{12'hF00, 12'h000, 12'h246, 12'h000, 12'h000};
    wire         sclW = !(sclOe | mSclLow);
    wire         sdaW = !(sdaOe | mSdaLow);
    initial forever #25 clk = !clk;
    atws_master m (.clk(clk), .sclW(sclW), .sdaW(sdaW), .sclLow(mSclLow), .sdaLow(mSdaLow));
    atws_slave dut (.clk(clk), .rst(rst), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .rawDiff(rawDiff),
        .resultCode(resultCode), .bipolarActive(bipolarActive), .convBusy(convBusy),
        .referenceSelect(referenceSelect), .externalClock(externalClock),
        .polaritySelect(polaritySelect), .scanSelect(scanSelect),
        .channelSelect(channelSelect), .singleEndedSelect(singleEndedSelect),
        .highSpeedMode(highSpeedMode), .busBusy(busBusy), .addressed(addressed),
        .readDir(readDir));
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sendAck(input logic [7:0] b, input logic exp);
        m.sendByte(b, ack);
        cmp(12'(ack), 12'(exp));
    endtask
    task automatic testDone;
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #3000000;
        errTotal++;
        testDone();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        cmp({referenceSelect, externalClock, polaritySelect}, 12'h000);
        cmp({scanSelect, channelSelect, singleEndedSelect}, 12'h001);
        cmp({highSpeedMode, busBusy}, 12'h000);
        cmp({sclOut, sdaOut, sclOe, sdaOe}, 12'h000);
        $display("reset values done");
        m.start();
        cmp(12'(busBusy), 12'h001);
        sendAck({`ATWS_OWN_ADDR, 1'b0}, 1'b1);
        sendAck(8'hA6, 1'b1);
        cmp(12'(addressed), 12'h001);
        sendAck(8'h4A, 1'b1);
        m.stop();
        cmp({referenceSelect, externalClock, polaritySelect}, 12'h009);
        cmp({scanSelect, channelSelect, singleEndedSelect}, 12'h04A);
        cmp({busBusy, bipolarActive}, 12'h001);
        $display("write cycle done");
        for (int k = 0; k < 5; k++) begin
            rawDiff = rawTab[k];
            m.start();
            sendAck({`ATWS_OWN_ADDR, 1'b0}, 1'b1);
            sendAck(suTab[k], 1'b1);
            m.start();
            sendAck({`ATWS_OWN_ADDR, 1'b1}, 1'b1);
            cmp(12'(readDir), 12'h001);
            m.stop();
            cmp(resultCode, expTab[k]);
        end
        cmp({scanSelect, channelSelect, singleEndedSelect}, 12'h001);
        cmp(12'(referenceSelect), 12'h002);
        $display("conversion coding done");
        m.start();
        sendAck({`ATWS_OWN_ADDR ^ 7'h01, 1'b0}, 1'b0);
        sendAck(8'h81, 1'b0);
        cmp(12'(addressed), 12'h000);
        m.stop();
        cmp(12'(singleEndedSelect), 12'h001);
        cmp(12'(referenceSelect), 12'h002);
        $display("address mismatch done");
        m.start();
        sendAck(8'h0D, 1'b0);
        repeat (4) @(negedge clk);
        cmp(12'(highSpeedMode), 12'h001);
        m.start();
        sendAck({`ATWS_OWN_ADDR, 1'b0}, 1'b1);
        sendAck(8'h4A, 1'b1);
        cmp(12'(highSpeedMode), 12'h001);
        m.stop();
        cmp(12'(highSpeedMode), 12'h000);
        $display("high speed mode done");
        testDone();
    end
endmodule
